// *** include/rtam_pkg.sv ***
package rtam_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS   = 8'h07;
  localparam logic [7:0] ADDR_INTCTL   = 8'h08;
  localparam logic [7:0] ADDR_INIT_AT  = 8'h0A;
  localparam logic [7:0] ADDR_INIT_DT  = 8'h0B;
  localparam logic [7:0] ADDR_GAINCTL  = 8'h0D;
  localparam logic [7:0] ADDR_FIN_AT   = 8'h0E;
  localparam logic [7:0] ADDR_FIN_DT   = 8'h0F;
  localparam logic [7:0] ADDR_ALARM0   = 8'h10;
  localparam logic [7:0] ADDR_ALARM5   = 8'h15;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h30;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h31;

  // Field positions, and the alarm byte count
  localparam int STAT_ALARM_BIT  = 6;
  localparam int INTCTL_ACLR_BIT = 7;
  localparam int INTCTL_RPT_BIT  = 6;
  localparam int INTCTL_FREQ_MSB = 3;
  localparam int GAIN_TSE_BIT    = 7;
  localparam int GAIN_BATTERY_COMP_ON_BIT   = 6;
  localparam int GAIN_BATTERY_COMP_RATE_SEL_BIT   = 5;
  localparam int ALARM_EN_BIT    = 7;
  localparam int DT_SIGN_BIT     = 4;
  localparam int IRQ_ALARM_BIT   = 0;
  localparam int IRQ_CONV_BIT    = 1;
  localparam int IRQ_BATLOW_BIT  = 2;
  localparam int ALARM_BYTES     = 6;

  // Values after reset, and the digital trim magnitude limit
  localparam logic [5:0] INIT_AT_RST  = 6'h20;
  localparam logic [4:0] INIT_DT_RST  = 5'h00;
  localparam logic [7:0] INTCTL_RST   = 8'h00;
  localparam logic [7:0] ALARM_RST    = 8'h00;
  localparam logic [2:0] IRQ_RST      = 3'h0;
  localparam logic [3:0] DT_MAG_MAX   = 4'hA;

  // Timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int CONV_TIME_MS    = 22;
  localparam int CONV_CYC        = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int PERIOD_SLOW_MIN = 10;
  localparam int PERIOD_FAST_MIN = 1;
  localparam int SEC_PER_MIN     = 60;
  localparam logic [9:0] PERIOD_SLOW_S =
    10'(PERIOD_SLOW_MIN * SEC_PER_MIN);
  localparam logic [9:0] PERIOD_FAST_S =
    10'(PERIOD_FAST_MIN * SEC_PER_MIN);
  localparam logic [7:0] IRQ_PULSE_CYC = 8'h64;

  // Clock bytes: seconds, minutes, hours, date, month, day of week
  typedef logic [ALARM_BYTES-1:0][7:0] rtam_time_type;

  // Trim pair: analog and sign-magnitude digital
  typedef struct packed {
    logic [5:0] analog_trim;
    logic [4:0] digital_trim;
  } rtam_trim_type;

  // Compensation sequencer, Gray along idle, convert, apply
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CONV  = 2'b01,
    ST_APPLY = 2'b11
  } rtam_state_type;

endpackage

// *** rtl/rtam_top.sv ***
// The strobed register port was decided locally.
`timescale 1ns/100ps
module rtam_top #(
  parameter int CONV_CYCLES = rtam_pkg::CONV_CYC
) (
  // Clock, reset, enable
  input  wire logic                    MCLK,
  input  wire logic                    RST_N,
  input  wire logic                    CE,
  // Register port
  input  wire logic [7:0]              REG_ADDR,
  input  wire logic [7:0]              REG_WDATA,
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  output logic      [7:0]              REG_RDATA,
  // Running clock bytes and one-second advance pulse
  input  wire rtam_pkg::rtam_time_type TIME_NOW,
  input  wire logic                    SEC_TICK,
  // Supply state and factory gain code
  input  wire logic                    ON_BATTERY,
  input  wire logic                    BATT_LOW,
  input  wire logic [4:0]              FACTORY_GAIN,
  // Temperature converter
  output logic                         CONV_ON,
  input  wire rtam_pkg::rtam_trim_type TEMP_TRIM,
  // Oscillator trim
  output rtam_pkg::rtam_trim_type      FINAL_TRIM,
  output logic      [5:0]              STEP_GAIN_16THS,
  // Alarm pin and frequency source
  input  wire logic                    FREQ_IN,
  output logic                         IRQ_OR_FREQ_OUT_N,
  output logic                         INT
);

  // Gain code to step size in sixteenths
  function automatic logic [5:0] gain_to_16ths(input logic [4:0] code);
    logic [5:0] mag;
    mag = {2'b00, code[3:0]};
    if (code[4])
      gain_to_16ths = 6'd17 + mag;
    else
      gain_to_16ths = 6'd16 - mag;
  endfunction

  // Limit a digital trim to a legal magnitude
  function automatic logic [4:0] clamp_dt(input logic [4:0] code);
    if (code[3:0] > rtam_pkg::DT_MAG_MAX)
      clamp_dt = {code[rtam_pkg::DT_SIGN_BIT], rtam_pkg::DT_MAG_MAX};
    else
      clamp_dt = code;
  endfunction

  logic [5:0]                init_at_r;
  logic [4:0]                init_dt_r;
  logic [4:0]                gain_r;
  logic                      tse_r;
  logic                      battery_comp_on_r;
  logic                      battery_comp_rate_sel_r;
  logic [7:0]                intctl_r;
  logic [7:0]                alarm_r [rtam_pkg::ALARM_BYTES];
  logic                      alarm_flag_r;
  logic [2:0]                irq_stat_r;
  logic [2:0]                irq_mask_r;
  logic [7:0]                rdata_r;
  logic [9:0]                sec_cnt_r;
  logic [21:0]               conv_cnt_r;
  rtam_pkg::rtam_state_type  state_r;
  rtam_pkg::rtam_state_type  state_nxt;
  rtam_pkg::rtam_trim_type   final_r;
  logic [7:0]                pulse_cnt_r;
  logic                      pin_r;
  logic                      tse_start_r;
  logic [rtam_pkg::ALARM_BYTES-1:0] byte_ok;
  logic [rtam_pkg::ALARM_BYTES-1:0] byte_en;
  logic                      alarm_hit;
  logic                      comp_on;
  logic                      batt_comp;
  logic [9:0]                period_s;
  logic                      period_due;
  logic                      conv_done;
  logic                      stat_rd;
  logic                      alm_clear;
  logic                      freq_sel;
  logic                      batlow_evt;
  logic [2:0]                irq_evt;
  logic                      tse_ok;
  logic                      conv_start;

  // Decoded strobes
  assign stat_rd   = REG_RD && REG_ADDR == rtam_pkg::ADDR_STATUS;
  assign freq_sel  = |intctl_r[rtam_pkg::INTCTL_FREQ_MSB:0];
  assign batt_comp = battery_comp_on_r && !BATT_LOW;
  assign comp_on   = ON_BATTERY ? batt_comp : tse_r;
  assign period_s  = battery_comp_rate_sel_r ? rtam_pkg::PERIOD_FAST_S
                            : rtam_pkg::PERIOD_SLOW_S;
  assign period_due = SEC_TICK && comp_on &&
                      sec_cnt_r >= period_s - 10'd1;
  assign conv_done = state_r == rtam_pkg::ST_CONV &&
                     conv_cnt_r == 22'(CONV_CYCLES - 1);

  // Per-byte alarm comparison, year has no byte
  generate
    for (genvar i = 0; i < rtam_pkg::ALARM_BYTES; i++) begin : g_cmp
      assign byte_en[i] = alarm_r[i][rtam_pkg::ALARM_EN_BIT];
      assign byte_ok[i] = !byte_en[i] ||
        alarm_r[i][6:0] == TIME_NOW[i][6:0];
    end
  endgenerate

  // Match only on a clock advance with some byte enabled
  assign alarm_hit = SEC_TICK && (|byte_en) && (&byte_ok);

  // Host clear of the alarm flag, by write or auto-clear read
  assign alm_clear =
    (REG_WR && REG_ADDR == rtam_pkg::ADDR_STATUS &&
     !REG_WDATA[rtam_pkg::STAT_ALARM_BIT]) ||
    (stat_rd && intctl_r[rtam_pkg::INTCTL_ACLR_BIT]);

  assign batlow_evt = battery_comp_on_r && BATT_LOW;
  assign irq_evt = {batlow_evt, conv_done, alarm_hit};

  // Sensing enable starts a conversion, not on a barred battery
  assign tse_ok     = !ON_BATTERY || batt_comp;
  assign conv_start = period_due || (tse_start_r && tse_ok);

  // Initial trim registers
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      init_at_r <= rtam_pkg::INIT_AT_RST;
      init_dt_r <= rtam_pkg::INIT_DT_RST;
    end else if (CE && REG_WR) begin
      if (REG_ADDR == rtam_pkg::ADDR_INIT_AT)
        init_at_r <= REG_WDATA[5:0];
      if (REG_ADDR == rtam_pkg::ADDR_INIT_DT)
        init_dt_r <= clamp_dt(REG_WDATA[4:0]);
    end
  end

  // Factory gain reloads at reset only
  // No clock enable here, so a reset edge is never missed
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      gain_r <= FACTORY_GAIN;
  end

  // Sensing controls; low battery knocks the battery enable off
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      tse_r       <= 1'b0;
      battery_comp_on_r      <= 1'b0;
      battery_comp_rate_sel_r      <= 1'b0;
      tse_start_r <= 1'b0;
    end else if (CE) begin
      tse_start_r <= 1'b0;
      if (REG_WR && REG_ADDR == rtam_pkg::ADDR_GAINCTL) begin
        tse_r  <= REG_WDATA[rtam_pkg::GAIN_TSE_BIT];
        battery_comp_on_r <= REG_WDATA[rtam_pkg::GAIN_BATTERY_COMP_ON_BIT] && !BATT_LOW;
        battery_comp_rate_sel_r <= REG_WDATA[rtam_pkg::GAIN_BATTERY_COMP_RATE_SEL_BIT];
        tse_start_r <= REG_WDATA[rtam_pkg::GAIN_TSE_BIT] && !tse_r;
      end else if (BATT_LOW) begin
        battery_comp_on_r <= 1'b0;
      end
    end
  end

  // Interrupt control and alarm bytes
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      intctl_r <= rtam_pkg::INTCTL_RST;
      for (int i = 0; i < rtam_pkg::ALARM_BYTES; i++)
        alarm_r[i] <= rtam_pkg::ALARM_RST;
    end else if (CE && REG_WR) begin
      if (REG_ADDR == rtam_pkg::ADDR_INTCTL)
        intctl_r <= REG_WDATA;
      if (REG_ADDR >= rtam_pkg::ADDR_ALARM0 &&
          REG_ADDR <= rtam_pkg::ADDR_ALARM5)
        alarm_r[3'(REG_ADDR - rtam_pkg::ADDR_ALARM0)] <= REG_WDATA;
    end
  end

  // Seconds since last conversion
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      sec_cnt_r <= 10'd0;
    else if (CE) begin
      if (!comp_on || period_due)
        sec_cnt_r <= 10'd0;
      else if (SEC_TICK)
        sec_cnt_r <= sec_cnt_r + 10'd1;
    end
  end

  // Compensation sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rtam_pkg::ST_IDLE:
        if (conv_start)
          state_nxt = rtam_pkg::ST_CONV;
      rtam_pkg::ST_CONV:
        if (conv_done)
          state_nxt = rtam_pkg::ST_APPLY;
      rtam_pkg::ST_APPLY:
        state_nxt = rtam_pkg::ST_IDLE;
      default:
        state_nxt = rtam_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      state_r <= rtam_pkg::ST_IDLE;
    else if (CE)
      state_r <= state_nxt;
  end

  // Conversion length counter
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      conv_cnt_r <= 22'd0;
    else if (CE) begin
      if (state_r == rtam_pkg::ST_CONV)
        conv_cnt_r <= conv_cnt_r + 22'd1;
      else
        conv_cnt_r <= 22'd0;
    end
  end

  // Trim in force: corrected after a conversion, else initial
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      final_r.analog_trim  <= rtam_pkg::INIT_AT_RST;
      final_r.digital_trim <= rtam_pkg::INIT_DT_RST;
    end else if (CE) begin
      if (!comp_on) begin
        final_r.analog_trim  <= init_at_r;
        final_r.digital_trim <= init_dt_r;
      end else if (state_r == rtam_pkg::ST_APPLY) begin
        final_r.analog_trim  <= TEMP_TRIM.analog_trim;
        final_r.digital_trim <= clamp_dt(TEMP_TRIM.digital_trim);
      end
    end
  end

  // Alarm flag, a new match wins over a clear
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      alarm_flag_r <= 1'b0;
    else if (CE) begin
      if (alarm_hit)
        alarm_flag_r <= 1'b1;
      else if (alm_clear)
        alarm_flag_r <= 1'b0;
    end
  end

  // Repeat-mode pulse timer
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      pulse_cnt_r <= 8'd0;
    else if (CE) begin
      if (alarm_hit && intctl_r[rtam_pkg::INTCTL_RPT_BIT])
        pulse_cnt_r <= rtam_pkg::IRQ_PULSE_CYC;
      else if (pulse_cnt_r != 8'd0)
        pulse_cnt_r <= pulse_cnt_r - 8'd1;
    end
  end

  // Pin: frequency, repeat pulse, or held single-event level
  // Registered so the pin never glitches between sources
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      pin_r <= 1'b1;
    else if (CE) begin
      if (freq_sel)
        pin_r <= FREQ_IN;
      else if (intctl_r[rtam_pkg::INTCTL_RPT_BIT])
        pin_r <= pulse_cnt_r == 8'd0;
      else
        pin_r <= !alarm_flag_r;
    end
  end

  // Sticky interrupt status, set wins over read clear
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      irq_stat_r <= rtam_pkg::IRQ_RST;
    else if (CE) begin
      if (REG_RD && REG_ADDR == rtam_pkg::ADDR_IRQ_STAT)
        irq_stat_r <= irq_evt;
      else
        irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // Interrupt mask
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      irq_mask_r <= rtam_pkg::IRQ_RST;
    else if (CE && REG_WR && REG_ADDR == rtam_pkg::ADDR_IRQ_MASK)
      irq_mask_r <= REG_WDATA[2:0];
  end

  // Read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      rdata_r <= 8'h00;
    else if (CE) begin
      rdata_r <= 8'h00;
      if (REG_RD) begin
        case (REG_ADDR)
          rtam_pkg::ADDR_STATUS:
            rdata_r[rtam_pkg::STAT_ALARM_BIT] <= alarm_flag_r;
          rtam_pkg::ADDR_INTCTL:
            rdata_r <= intctl_r;
          rtam_pkg::ADDR_INIT_AT:
            rdata_r <= {2'b00, init_at_r};
          rtam_pkg::ADDR_INIT_DT:
            rdata_r <= {3'b000, init_dt_r};
          rtam_pkg::ADDR_GAINCTL:
            rdata_r <= {tse_r, battery_comp_on_r, battery_comp_rate_sel_r, gain_r};
          rtam_pkg::ADDR_FIN_AT:
            rdata_r <= {2'b00, final_r.analog_trim};
          rtam_pkg::ADDR_FIN_DT:
            rdata_r <= {3'b000, final_r.digital_trim};
          rtam_pkg::ADDR_IRQ_STAT:
            rdata_r <= {5'h00, irq_stat_r};
          rtam_pkg::ADDR_IRQ_MASK:
            rdata_r <= {5'h00, irq_mask_r};
          default:
            if (REG_ADDR >= rtam_pkg::ADDR_ALARM0 &&
                REG_ADDR <= rtam_pkg::ADDR_ALARM5)
              rdata_r <= alarm_r[3'(REG_ADDR - rtam_pkg::ADDR_ALARM0)];
        endcase
      end
    end
  end

  // Step gain register
  always_ff @(posedge MCLK) begin
    if (!RST_N)
      STEP_GAIN_16THS <= 6'd16;
    else if (CE)
      STEP_GAIN_16THS <= gain_to_16ths(gain_r);
  end

  // Outputs
  assign REG_RDATA         = rdata_r;
  assign FINAL_TRIM        = final_r;
  assign CONV_ON           = state_r == rtam_pkg::ST_CONV;
  assign IRQ_OR_FREQ_OUT_N = pin_r;
  assign INT               = |(irq_stat_r & irq_mask_r);

endmodule

// *** tb/rtam_asserts.sv ***
`timescale 1ns/100ps
// Port-level checks of the trim monitor and alarm block
module rtam_asserts #(
  parameter int CONV_CYCLES = rtam_pkg::CONV_CYC
) (
  // Clock, reset, register port
  input wire logic                    MCLK,
  input wire logic                    RST_N,
  input wire logic [7:0]              REG_ADDR,
  input wire logic                    REG_RD,
  input wire logic [7:0]              REG_RDATA,
  // Supply, gain, trims, alarm
  input wire logic                    ON_BATTERY,
  input wire logic                    BATT_LOW,
  input wire logic [4:0]              FACTORY_GAIN,
  input wire logic                    CONV_ON,
  input wire rtam_pkg::rtam_trim_type TEMP_TRIM,
  input wire rtam_pkg::rtam_trim_type FINAL_TRIM,
  input wire logic [5:0]              STEP_GAIN_16THS,
  input wire logic                    SEC_TICK,
  input wire logic                    IRQ_OR_FREQ_OUT_N
);
  int conv_len_r;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  // Step gain in sixteenths for a gain code
  function automatic logic [5:0] gain16(input logic [4:0] c);
    gain16 = c[4] ? 6'h11 + {2'h0, c[3:0]} : 6'h10 - {2'h0, c[3:0]};
  endfunction

  // Cycles spent converting
  always_ff @(posedge MCLK) begin
    if (!RST_N || !CONV_ON) begin
      conv_len_r <= 0;
    end else begin
      conv_len_r <= conv_len_r + 1;
    end
  end

  property p_rd_idle; !$past(REG_RD) |-> REG_RDATA == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("Read data not idle");
  property p_rd_at;
    REG_RD && REG_ADDR == rtam_pkg::ADDR_FIN_AT
      |=> REG_RDATA == {2'b00, $past(FINAL_TRIM.analog_trim)};
  endproperty
  a_rd_at: assert property (p_rd_at)
    else $error("Final analog view wrong");
  property p_rd_dt;
    REG_RD && REG_ADDR == rtam_pkg::ADDR_FIN_DT
      |=> REG_RDATA == {3'b000, $past(FINAL_TRIM.digital_trim)};
  endproperty
  a_rd_dt: assert property (p_rd_dt)
    else $error("Final digital view wrong");
  property p_gain;
    $rose(RST_N) |=> STEP_GAIN_16THS == gain16($past(FACTORY_GAIN, 2));
  endproperty
  a_gain: assert property (p_gain)
    else $error("Step gain wrong");
  property p_conv_len; $fell(CONV_ON) |-> conv_len_r == CONV_CYCLES;
  endproperty
  a_conv_len: assert property (p_conv_len)
    else $error("Conversion length wrong");
  property p_apply;
    $fell(CONV_ON) |=> FINAL_TRIM.analog_trim == $past(TEMP_TRIM.analog_trim);
  endproperty
  a_apply: assert property (p_apply)
    else $error("Trim not applied");
  property p_low_batt;
    ON_BATTERY && BATT_LOW && !CONV_ON |=> !CONV_ON;
  endproperty
  a_low_batt: assert property (p_low_batt)
    else $error("Conversion on low battery");
  property p_pin_cause;
    $fell(IRQ_OR_FREQ_OUT_N) |-> $past(SEC_TICK, 2);
  endproperty
  a_pin_cause: assert property (p_pin_cause)
    else $error("Alarm pin fell without a tick");

  // Main scenarios reached
  c_conv: cover property ($fell(CONV_ON));
  c_alarm: cover property ($fell(IRQ_OR_FREQ_OUT_N));
  c_release: cover property ($rose(IRQ_OR_FREQ_OUT_N));
endmodule

// *** tb/rtam_tb.sv ***
`timescale 1ns/100ps
// Directed bench for the trim monitor and alarm block
module rtam_tb;
  localparam int CONV_N = 20;
  localparam int LIMIT  = 20000;
  logic                    mclk;
  logic                    rst_n;
  logic [7:0]              reg_addr;
  logic [7:0]              reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [7:0]              reg_rdata;
  rtam_pkg::rtam_time_type time_now;
  logic                    sec_tick;
  logic                    on_battery;
  logic                    batt_low;
  logic [4:0]              factory_gain;
  logic                    conv_on;
  rtam_pkg::rtam_trim_type temp_trim;
  rtam_pkg::rtam_trim_type final_trim;
  logic [5:0]              step_gain;
  logic                    irq_n;
  logic                    freq_in;
  logic                    int_out;
  int                      error_cnt;
  int                      n_tests;
  int                      cyc_cnt;
  int                      n;
  logic [7:0]              d;
  logic [4:0]              g_code [5] = '{5'h00, 5'h08, 5'h01, 5'h10, 5'h1F};
  logic [5:0]              g_x16 [5] = '{6'h10, 6'h08, 6'h0F, 6'h11, 6'h20};

  rtam_top #(.CONV_CYCLES(CONV_N)) DUT (
    .MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .TIME_NOW(time_now), .SEC_TICK(sec_tick),
    .ON_BATTERY(on_battery), .BATT_LOW(batt_low),
    .FACTORY_GAIN(factory_gain), .CONV_ON(conv_on),
    .TEMP_TRIM(temp_trim), .FINAL_TRIM(final_trim),
    .STEP_GAIN_16THS(step_gain), .FREQ_IN(freq_in),
    .IRQ_OR_FREQ_OUT_N(irq_n), .INT(int_out)
  );

  // Compare one result
  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  // Report counts and end the run
  task automatic close_out;
    $display("Mismatches %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask
  // Register write and read, data taken the cycle after the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic tick;
    @(posedge mclk);
    sec_tick <= 1'b1;
    @(posedge mclk);
    sec_tick <= 1'b0;
  endtask
  task automatic rst(input int k);
    @(posedge mclk);
    rst_n <= 1'b0;
    cyc(k);
    rst_n <= 1'b1;
    cyc(2);
  endtask
  // Count seconds until a conversion starts
  task automatic meas(input int lim);
    n = 0;
    do begin
      tick();
      n++;
      @(posedge mclk);
      #1;
    end while (conv_on !== 1'b1 && n < lim);
    cyc(CONV_N + 4);
  endtask
  // Alarm pin after a tick
  task automatic alarm(input logic e);
    tick();
    cyc(2);
    #1;
    chk("pin", 16'(e), 16'(irq_n));
  endtask

  // Clock and cycle ceiling
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == LIMIT) begin
      error_cnt++;
      close_out();
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    time_now = '0;
    sec_tick = 1'b0;
    on_battery = 1'b0;
    batt_low = 1'b0;
    freq_in = 1'b0;
    factory_gain = 5'h00;
    temp_trim = '0;
    error_cnt = 0;
    n_tests = 0;
    cyc_cnt = 0;
    foreach (g_code[i]) begin
      factory_gain <= g_code[i];
      rst(8);
      chk("step gain", 16'(g_x16[i]), 16'(step_gain));
      rd(8'h0D);
      chk("gain field", 16'(g_code[i]), 16'(d & 8'h1F));
    end
    wr(8'h0D, 8'h00);
    rd(8'h0D);
    chk("gain kept", 16'h001F, 16'(d));
    wr(8'h0E, 8'hFF);
    rd(8'h0E);
    chk("final analog", 16'h0020, 16'(d));
    wr(8'h0F, 8'hFF);
    rd(8'h0F);
    chk("final digital", 16'h0000, 16'(d));
    wr(8'h16, 8'h81);
    rd(8'h16);
    chk("no year byte", 16'h0000, 16'(d));
    wr(8'h0A, 8'h15);
    wr(8'h0B, 8'h13);
    rd(8'h0F);
    chk("initial digital", 16'h0013, 16'(d));
    // Sensing enable starts one conversion
    temp_trim <= '{6'h11, 5'h05};
    wr(8'h0D, 8'h80);
    cyc(CONV_N + 4);
    rd(8'h0E);
    chk("corrected analog", 16'h0011, 16'(d));
    chk("int masked", 16'h0000, 16'(int_out));
    wr(8'h31, 8'h02);
    #1;
    chk("int raised", 16'h0001, 16'(int_out));
    rd(8'h30);
    chk("conv event", 16'h0002, 16'(d & 8'h02));
    chk("int cleared", 16'h0000, 16'(int_out));
    wr(8'h0D, 8'h00);
    rd(8'h0E);
    chk("initial analog", 16'h0015, 16'(d));
    // Battery mode periods and refusals
    on_battery <= 1'b1;
    temp_trim <= '{6'h2A, 5'h1F};
    wr(8'h0D, 8'h60);
    meas(61);
    meas(61);
    chk("fast period", 16'h003C, 16'(n));
    rd(8'h0F);
    chk("clamped digital", 16'h001A, 16'(d));
    wr(8'h0D, 8'h40);
    meas(601);
    meas(601);
    chk("slow period", 16'h0258, 16'(n));
    wr(8'h0D, 8'h20);
    meas(70);
    chk("comp off", 16'h0046, 16'(n));
    rd(8'h30);
    // Low battery arrives while the battery enable is set
    wr(8'h0D, 8'h60);
    batt_low <= 1'b1;
    meas(70);
    chk("low battery", 16'h0046, 16'(n));
    rd(8'h0D);
    chk("battery enable off", 16'h0000, 16'(d & 8'h40));
    rd(8'h30);
    chk("low event", 16'h0004, 16'(d & 8'h04));
    batt_low <= 1'b0;
    on_battery <= 1'b0;
    wr(8'h0D, 8'h00);
    // Single alarm on the minute byte, hour byte disabled
    wr(8'h11, 8'hB0);
    wr(8'h12, 8'h11);
    wr(8'h31, 8'h01);
    time_now[1] <= 8'h31;
    time_now[2] <= 8'h05;
    alarm(1'b1);
    time_now[1] <= 8'h30;
    alarm(1'b0);
    cyc(150);
    rd(8'h07);
    chk("held low", 16'h0000, 16'(irq_n));
    chk("flag", 16'h0040, 16'(d & 8'h40));
    chk("int alarm", 16'h0001, 16'(int_out));
    wr(8'h07, 8'h00);
    cyc(2);
    #1;
    chk("cleared", 16'h0001, 16'(irq_n));
    // Auto-clear by status read
    wr(8'h08, 8'h80);
    alarm(1'b0);
    rd(8'h07);
    cyc(2);
    #1;
    chk("auto clear", 16'h0001, 16'(irq_n));
    rd(8'h07);
    chk("flag gone", 16'h0000, 16'(d & 8'h40));
    // Repeating pulses without rearming
    wr(8'h08, 8'h40);
    repeat (2) begin
      alarm(1'b0);
      n = 1;
      while (irq_n === 1'b0 && n < 200) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk("pulse width", 16'h0064, 16'(n));
    end
    // Frequency select takes the pin over from a running pulse
    freq_in <= 1'b1;
    alarm(1'b0);
    wr(8'h08, 8'h41);
    cyc(1);
    #1;
    chk("freq out", 16'h0001, 16'(irq_n));
    close_out();
  end
endmodule

bind rtam_top rtam_asserts #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .ON_BATTERY(ON_BATTERY), .BATT_LOW(BATT_LOW),
  .FACTORY_GAIN(FACTORY_GAIN), .CONV_ON(CONV_ON), .TEMP_TRIM(TEMP_TRIM),
  .FINAL_TRIM(FINAL_TRIM), .STEP_GAIN_16THS(STEP_GAIN_16THS),
  .SEC_TICK(SEC_TICK), .IRQ_OR_FREQ_OUT_N(IRQ_OR_FREQ_OUT_N)
);
